// ---- hdl/pdc_pkg.sv ----
// constants and types of the power-down control block
//------------------------------------------------------------------
//------------------------------------------------------------------
package pdc_pkg;

    // clock
    localparam int unsigned CLK_PERIOD_PS = 10000;

    // interval minimum times in ps and clock counts
    localparam int unsigned T_CMD_ENTRY_PS  = 1750;
    localparam int unsigned N_CMD_ENTRY     = 3;
    localparam int unsigned T_EXIT_LAT_PS   = 7500;
    localparam int unsigned N_EXIT_LAT      = 5;
    localparam int unsigned T_CLK_ENTRY_PS  = 5000;
    localparam int unsigned N_CLK_ENTRY     = 5;
    localparam int unsigned T_CS_ENTRY_PS   = 5000;
    localparam int unsigned N_CS_ENTRY      = 5;
    localparam int unsigned T_PULSE_PS      = 7500;
    localparam int unsigned N_PULSE         = 4;

    // an interval expires when both time and count are met
    function automatic int unsigned both_met(input int unsigned ps, input int unsigned nck);
        int unsigned c;
        c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (c > nck) ? c : nck;
    endfunction

    localparam int unsigned CYC_CMD_ENTRY = both_met(T_CMD_ENTRY_PS, N_CMD_ENTRY);
    localparam int unsigned CYC_EXIT_LAT  = both_met(T_EXIT_LAT_PS, N_EXIT_LAT);
    localparam int unsigned CYC_CLK_ENTRY = both_met(T_CLK_ENTRY_PS, N_CLK_ENTRY);
    localparam int unsigned CYC_CS_ENTRY  = both_met(T_CS_ENTRY_PS, N_CS_ENTRY);
    localparam int unsigned CYC_PULSE     = both_met(T_PULSE_PS, N_PULSE);

    // register bus
    localparam int unsigned ADDR_W = 3;
    localparam int unsigned DATA_W = 8;
    localparam logic [2:0] REG_TERMINATION_CONFIG = 3'h0;
    localparam logic [2:0] REG_BURST_POSTAMBLE    = 3'h1;
    localparam logic [2:0] REG_CMD_TERM_OPTION    = 3'h2;
    localparam logic [2:0] REG_STATUS             = 3'h3;
    localparam logic [2:0] REG_VIOLATION          = 3'h4;

    // field positions and reset values
    localparam int unsigned TERM_EN_LSB      = 4;
    localparam int unsigned POSTAMBLE_BIT    = 7;
    localparam logic [7:0]  TERM_CFG_RST     = 8'h00;
    localparam logic [7:0]  POSTAMBLE_RST    = 8'h00;
    localparam logic [7:0]  TERM_OPT_RST     = 8'h00;

    // violation flag positions
    localparam int unsigned VIO_BUSY_ENTRY = 0;
    localparam int unsigned VIO_PULSE      = 1;
    localparam int unsigned VIO_EXIT_CMD   = 2;
    localparam int unsigned VIO_CS_HOLD    = 3;
    localparam int unsigned VIO_CMD_ENTRY  = 4;
    localparam int unsigned VIO_W          = 5;

    // power-down classification
    typedef enum logic [1:0] {
        PDM_NONE   = 2'h0,
        PDM_IDLE   = 2'h1,
        PDM_ACTIVE = 2'h2,
        PDM_SELF   = 2'h3
    } pdc_mode_t;

    // link state, one-hot
    typedef enum logic [3:0] {
        ST_AWAKE = 4'b0001,
        ST_ENTRY = 4'b0010,
        ST_DOWN  = 4'b0100,
        ST_EXIT  = 4'b1000
    } pdc_state_t;

endpackage

// ---- hdl/pdc_timer.sv ----
// minimum-interval timer, restartable
`timescale 1ns/100ps
`default_nettype none
module pdc_timer
    import pdc_pkg::*;
#(
    parameter int unsigned CYCLES = 4
) (
    // clock and reset
    input  wire logic  i_ref_clk,
    input  wire logic  i_rst_n,
    // control
    pdc_tmr_if.timer   tmr
);
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic       done_q;

    // a restart wins over a running count
    assign cnt_d = tmr.start ? 4'(CYCLES) :
                   (cnt_q != 4'h0) ? cnt_q - 4'h1 : 4'h0;

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_q  <= 4'h0;
            done_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            done_q <= !tmr.start && (cnt_q == 4'h1);
        end
    end

    assign tmr.run  = (cnt_q != 4'h0);
    assign tmr.done = done_q;
endmodule // pdc_timer
`default_nettype wire

// ---- hdl/pdc_tmr_if.sv ----
// start and status wires between the controller and one interval timer
`timescale 1ns/100ps
`default_nettype none
interface pdc_tmr_if;
    logic start;   // restart the interval
    logic run;     // interval not yet elapsed
    logic done;    // one-cycle pulse at expiry

    modport owner (output start, input run, input done);
    modport timer (input start, output run, output done);
endinterface // pdc_tmr_if
`default_nettype wire

// ---- hdl/pdc_top.sv ----
// power-down entry and exit control of the memory die
`timescale 1ns/100ps
`default_nettype none
module pdc_top
    import pdc_pkg::*;
(
    // clock and reset
    input  wire logic                i_ref_clk,
    input  wire logic                i_arst_n,
    // memory link pins
    input  wire logic                i_cke,
    input  wire logic                i_cs,
    input  wire logic [5:0]          i_cmd_addr_bus,
    // core status
    input  wire logic                i_any_row_open,
    input  wire logic                i_self_refresh,
    input  wire logic                i_op_busy,
    input  wire logic                i_protected_busy,
    input  wire logic                i_cmd_needs_delay,
    input  wire logic                i_term_pad_en,
    // register port
    input  wire logic [ADDR_W-1:0]   i_reg_addr,
    input  wire logic [DATA_W-1:0]   i_reg_wdata,
    input  wire logic                i_reg_wr,
    input  wire logic                i_reg_rd,
    output logic      [DATA_W-1:0]   o_reg_rdata,
    // power-down outputs
    output logic                     o_io_buf_en,
    output logic                     o_rx_en,
    output logic                     o_refresh_en,
    output logic                     o_pd_current_ok,
    output logic      [1:0]          o_pd_mode,
    output logic      [2:0]          o_cmd_term_en,
    output logic                     o_long_postamble,
    output logic                     o_cmd_accept,
    output logic      [5:0]          o_cmd_word
);

    //------------------------------------------------------------------
    // reset release
    //------------------------------------------------------------------
    logic rst_meta_q;
    logic rst_n_q;

    // async assert, two-flop release so no flop leaves reset on a skewed edge
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    //------------------------------------------------------------------
    // interval timers
    //------------------------------------------------------------------
    pdc_tmr_if clk_hold ();
    pdc_tmr_if cs_hold ();
    pdc_tmr_if pulse ();
    pdc_tmr_if exit_lat ();
    pdc_tmr_if cmd_entry ();

    pdc_timer #(.CYCLES(CYC_CLK_ENTRY)) u_clk_hold (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (rst_n_q),
        .tmr       (clk_hold)
    );
    pdc_timer #(.CYCLES(CYC_CS_ENTRY)) u_cs_hold (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (rst_n_q),
        .tmr       (cs_hold)
    );
    pdc_timer #(.CYCLES(CYC_PULSE)) u_pulse (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (rst_n_q),
        .tmr       (pulse)
    );
    pdc_timer #(.CYCLES(CYC_EXIT_LAT)) u_exit_lat (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (rst_n_q),
        .tmr       (exit_lat)
    );
    pdc_timer #(.CYCLES(CYC_CMD_ENTRY)) u_cmd_entry (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (rst_n_q),
        .tmr       (cmd_entry)
    );

    //------------------------------------------------------------------
    // enable pin tracking
    //------------------------------------------------------------------
    logic cke_q;
    logic cmd_seen;
    logic cke_edge;
    logic cke_fall;
    logic cke_rise;

    always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cke_q <= 1'b1;
        end else begin
            cke_q <= i_cke;
        end
    end

    assign cke_edge = (i_cke != cke_q);
    assign cke_fall = cke_q && !i_cke;
    assign cke_rise = !cke_q && i_cke;

    //------------------------------------------------------------------
    // power-down state machine
    //------------------------------------------------------------------
    pdc_state_t state_q;
    pdc_state_t state_d;

    // entry and exit follow the pin level, with no command needed
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_AWAKE: begin
                if (!i_cke) state_d = ST_ENTRY;
            end
            ST_ENTRY: begin
                if (i_cke) begin
                    state_d = ST_EXIT;
                end else if (clk_hold.done) begin
                    state_d = ST_DOWN;
                end
            end
            ST_DOWN: begin
                if (i_cke) state_d = ST_EXIT;
            end
            ST_EXIT: begin
                if (!i_cke) begin
                    state_d = ST_ENTRY;
                end else if (exit_lat.done) begin
                    state_d = ST_AWAKE;
                end
            end
            default: state_d = ST_AWAKE;
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q <= ST_AWAKE;
        end else begin
            state_q <= state_d;
        end
    end

    // timer starts
    assign clk_hold.start  = cke_fall;
    assign cs_hold.start   = cke_fall;
    assign pulse.start     = cke_edge;
    assign exit_lat.start  = cke_rise;
    assign cmd_entry.start = cmd_seen && i_cmd_needs_delay;

    //------------------------------------------------------------------
    // command path
    //------------------------------------------------------------------
    logic in_pd_d;
    logic cmd_ok;

    assign in_pd_d  = (state_d == ST_ENTRY) || (state_d == ST_DOWN);
    assign cmd_seen = i_cs && i_cke && cke_q;
    // only the awake state executes; during entry hold the bus is ignored
    assign cmd_ok   = cmd_seen && (state_q == ST_AWAKE);

    always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            o_cmd_accept <= 1'b0;
            o_cmd_word   <= 6'h00;
        end else begin
            o_cmd_accept <= cmd_ok;
            o_cmd_word   <= cmd_ok ? i_cmd_addr_bus : 6'h00;
        end
    end

    //------------------------------------------------------------------
    // classification and buffer control
    //------------------------------------------------------------------
    pdc_mode_t mode_q;
    pdc_mode_t mode_entry;

    // classified at the moment of entry
    assign mode_entry = i_self_refresh ? PDM_SELF :
                        i_any_row_open ? PDM_ACTIVE : PDM_IDLE;

    always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            mode_q <= PDM_NONE;
        end else if (!in_pd_d) begin
            mode_q <= PDM_NONE;
        end else if (state_q == ST_AWAKE || state_q == ST_EXIT) begin
            mode_q <= mode_entry;
        end
    end

    // outputs follow the next state so they change on the sampling edge
    always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            o_io_buf_en     <= 1'b1;
            o_rx_en         <= 1'b1;
            o_refresh_en    <= 1'b1;
            o_pd_current_ok <= 1'b0;
        end else begin
            o_io_buf_en     <= !in_pd_d;
            o_rx_en         <= (state_d != ST_DOWN);
            o_refresh_en    <= !in_pd_d || i_self_refresh;
            o_pd_current_ok <= in_pd_d && !i_op_busy;
        end
    end

    assign o_pd_mode = mode_q;

    //------------------------------------------------------------------
    // registers
    //------------------------------------------------------------------
    logic [7:0]       term_cfg_q;
    logic [7:0]       postamble_q;
    logic [7:0]       term_opt_q;
    logic [VIO_W-1:0] vio_q;
    logic [VIO_W-1:0] vio_set;
    logic [VIO_W-1:0] vio_clr;
    logic             wr_term;
    logic             wr_post;
    logic             wr_opt;
    logic             wr_vio;
    logic [7:0]       status_word;
    logic [7:0]       rd_mux;

    assign wr_term = i_reg_wr && (i_reg_addr == REG_TERMINATION_CONFIG);
    assign wr_post = i_reg_wr && (i_reg_addr == REG_BURST_POSTAMBLE);
    assign wr_opt  = i_reg_wr && (i_reg_addr == REG_CMD_TERM_OPTION);
    assign wr_vio  = i_reg_wr && (i_reg_addr == REG_VIOLATION);

    always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            term_cfg_q  <= TERM_CFG_RST;
            postamble_q <= POSTAMBLE_RST;
            term_opt_q  <= TERM_OPT_RST;
        end else begin
            if (wr_term) term_cfg_q <= i_reg_wdata;
            if (wr_post) postamble_q <= i_reg_wdata;
            if (wr_opt) term_opt_q <= i_reg_wdata;
        end
    end

    // termination needs both the field and the pad or option; state is not consulted
    always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            o_cmd_term_en    <= 3'h0;
            o_long_postamble <= 1'b0;
        end else begin
            o_cmd_term_en    <= term_cfg_q[TERM_EN_LSB +: 3]
                                & ({3{i_term_pad_en}} | term_opt_q[2:0]);
            o_long_postamble <= postamble_q[POSTAMBLE_BIT];
        end
    end

    //------------------------------------------------------------------
    // controller misbehaviour flags
    //------------------------------------------------------------------
    // flags are diagnostics only: the die does not refuse the pin change
    always_comb begin
        vio_set = '0;
        vio_set[VIO_BUSY_ENTRY] = cke_fall && i_protected_busy;
        vio_set[VIO_PULSE]      = cke_edge && pulse.run;
        vio_set[VIO_EXIT_CMD]   = cmd_seen && (state_q == ST_EXIT);
        vio_set[VIO_CS_HOLD]    = i_cs && !i_cke && cs_hold.run;
        vio_set[VIO_CMD_ENTRY]  = cke_fall && cmd_entry.run;
    end

    assign vio_clr = wr_vio ? i_reg_wdata[VIO_W-1:0] : '0;

    // write-one-to-clear; a set in the same cycle wins
    always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            vio_q <= '0;
        end else begin
            vio_q <= (vio_q & ~vio_clr) | vio_set;
        end
    end

    assign status_word = {state_q, mode_q, o_rx_en, o_io_buf_en};

    // unmapped addresses read zero
    always_comb begin
        case (i_reg_addr)
            REG_TERMINATION_CONFIG: rd_mux = term_cfg_q;
            REG_BURST_POSTAMBLE:    rd_mux = postamble_q;
            REG_CMD_TERM_OPTION:    rd_mux = term_opt_q;
            REG_STATUS:             rd_mux = status_word;
            REG_VIOLATION:          rd_mux = {{(8-VIO_W){1'b0}}, vio_q};
            default:                rd_mux = 8'h00;
        endcase
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            o_reg_rdata <= 8'h00;
        end else begin
            o_reg_rdata <= i_reg_rd ? rd_mux : 8'h00;
        end
    end

endmodule // pdc_top
`default_nettype wire

// ---- sim/pdc_ctl_model.sv ----
// memory controller model driving enable, select and command bus
`timescale 1ns/100ps
`default_nettype none
module pdc_ctl_model
    import pdc_pkg::*;
(
    // clock
    input  wire logic  i_ref_clk,
    // link pins towards the die
    output logic       o_cke,
    output logic       o_cs,
    output logic [5:0] o_cmd,
    output logic       o_needs_delay
);
    int unsigned since_cmd = 99; // cycles since a delayed command
    // the clock runs free, so it is stable around every window
    initial begin
        o_cke = 1'h1;
        o_cs = 1'h0;
        o_cmd = 6'h3F;
        o_needs_delay = 1'h0;
    end
    // idle cycles: the unselected bus toggles so a stale word cannot pass
    task automatic step(input int n);
        repeat (n) begin
            @(posedge i_ref_clk);
            o_cs <= 1'h0;
            o_needs_delay <= 1'h0;
            o_cmd <= ~o_cmd;
            since_cmd++;
        end
    endtask
    // one command cycle
    task automatic issue(input logic [5:0] w, input logic dly);
        @(posedge i_ref_clk);
        o_cs <= 1'h1;
        o_cmd <= w;
        o_needs_delay <= dly;
        if (dly) since_cmd = 0;
        step(1);
    endtask
    // bad[0] skips the command-to-entry wait, bad[1] raises select in the hold
    task automatic pd_enter(input logic [1:0] bad);
        if (!bad[0])
            while (since_cmd < CYC_CMD_ENTRY + 1) step(1);
        @(posedge i_ref_clk);
        o_cke <= 1'h0;
        if (bad[1]) begin
            @(posedge i_ref_clk);
            o_cs <= 1'h1;
        end
    endtask
    // rush leaves out the exit latency wait
    task automatic pd_exit(input logic rush);
        @(posedge i_ref_clk);
        o_cke <= 1'h1;
        if (!rush) step(CYC_EXIT_LAT + 2);
    endtask
endmodule // pdc_ctl_model
`default_nettype wire

// ---- sim/pdc_properties.sv ----
// port assertions of the power-down control block
`timescale 1ns/100ps
`default_nettype none
module pdc_properties
    import pdc_pkg::*;
(
    // clock and reset
    input wire logic       i_ref_clk,
    input wire logic       i_arst_n,
    // link and core inputs
    input wire logic       i_cke,
    input wire logic       i_cs,
    input wire logic       i_any_row_open,
    input wire logic       i_self_refresh,
    input wire logic       i_op_busy,
    input wire logic       i_reg_wr,
    // watched outputs
    input wire logic       o_io_buf_en,
    input wire logic       o_rx_en,
    input wire logic       o_refresh_en,
    input wire logic       o_pd_current_ok,
    input wire logic [1:0] o_pd_mode,
    input wire logic [2:0] o_cmd_term_en,
    input wire logic       o_cmd_accept
);
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_arst_n);
    // mode the core asks for; the bench holds core inputs across an entry
    wire logic [1:0] want_mode;
    assign want_mode = i_self_refresh ? PDM_SELF : (i_any_row_open ? PDM_ACTIVE : PDM_IDLE);
    // cycles the enable pin has been seen low, saturating; avoids a long repetition
    logic [3:0] low_cnt;
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            low_cnt <= 4'h0;
        end else if (i_cke) begin
            low_cnt <= 4'h0;
        end else if (low_cnt != 4'hF) begin
            low_cnt <= low_cnt + 4'h1;
        end
    end

    property p_entry;
        $fell(i_cke) |-> ##[1:2] !o_io_buf_en;
    endproperty
    a_entry: assert property (p_entry)
        else $error("buffers stayed on after entry");
    property p_rx_hold;
        $fell(i_cke) |-> o_rx_en [*5];
    endproperty
    a_rx_hold: assert property (p_rx_hold)
        else $error("receivers off too early");
    property p_rx_off;
        (!i_cke && low_cnt >= 4'h9) |-> !o_rx_en;
    endproperty
    a_rx_off: assert property (p_rx_off)
        else $error("receivers still on in power-down");
    property p_exit;
        $rose(i_cke) |-> ##[1:2] (o_io_buf_en && o_rx_en && o_pd_mode == PDM_NONE);
    endproperty
    a_exit: assert property (p_exit)
        else $error("no exit after enable rose");
    property p_mode;
        $fell(i_cke) |-> ##[1:2] (o_pd_mode == want_mode);
    endproperty
    a_mode: assert property (p_mode)
        else $error("wrong power-down mode");
    property p_no_refresh;
        (o_pd_mode == PDM_IDLE || o_pd_mode == PDM_ACTIVE) |-> !o_refresh_en;
    endproperty
    a_no_refresh: assert property (p_no_refresh)
        else $error("refresh on in idle or active power-down");
    property p_self;
        o_pd_mode == PDM_SELF |-> o_refresh_en;
    endproperty
    a_self: assert property (p_self)
        else $error("refresh off in self-refresh power-down");
    property p_accept;
        o_cmd_accept |-> $past(i_cs) && $past(i_cke) && $past(i_cke, 2);
    endproperty
    a_accept: assert property (p_accept)
        else $error("command taken while enable low");
    property p_xp;
        $rose(i_cke) |-> (!o_cmd_accept) [*6];
    endproperty
    a_xp: assert property (p_xp)
        else $error("command taken inside exit latency");
    property p_current;
        i_op_busy && $past(i_op_busy) |-> !o_pd_current_ok;
    endproperty
    a_current: assert property (p_current)
        else $error("low current state while core busy");
    property p_term;
        $fell(i_cke) && !i_reg_wr |=> $stable(o_cmd_term_en);
    endproperty
    a_term: assert property (p_term)
        else $error("termination changed on entry");
endmodule // pdc_properties

bind pdc_top pdc_properties u_props (
    .i_ref_clk, .i_arst_n, .i_cke, .i_cs, .i_any_row_open, .i_self_refresh, .i_op_busy,
    .i_reg_wr, .o_io_buf_en, .o_rx_en, .o_refresh_en, .o_pd_current_ok, .o_pd_mode,
    .o_cmd_term_en, .o_cmd_accept
);
`default_nettype wire

// ---- sim/testbench.sv ----
// self-checking bench of the power-down control block
`timescale 1ns/100ps
`default_nettype none
module testbench
    import pdc_pkg::*;
;
    logic              i_ref_clk = 1'h0;
    logic              i_arst_n = 1'h0;
    wire logic         i_cke, i_cs, i_cmd_needs_delay;
    wire logic [5:0]   i_cmd_addr_bus;
    logic              i_any_row_open = 1'h0, i_self_refresh = 1'h0, i_op_busy = 1'h0;
    logic              i_protected_busy = 1'h0, i_term_pad_en = 1'h0;
    logic [ADDR_W-1:0] i_reg_addr = '0;
    logic [DATA_W-1:0] i_reg_wdata = '0;
    logic              i_reg_wr = 1'h0, i_reg_rd = 1'h0;
    logic [DATA_W-1:0] o_reg_rdata;
    logic              o_io_buf_en, o_rx_en, o_refresh_en, o_pd_current_ok;
    logic              o_long_postamble, o_cmd_accept;
    logic [1:0]        o_pd_mode;
    logic [2:0]        o_cmd_term_en;
    logic [5:0]        o_cmd_word, last_word;
    int                num_errors = 0, n_checks = 0, cycles = 0, n_acc = 0;

    always #5 i_ref_clk = ~i_ref_clk;

    pdc_ctl_model ctl (.i_ref_clk, .o_cke(i_cke), .o_cs(i_cs), .o_cmd(i_cmd_addr_bus),
        .o_needs_delay(i_cmd_needs_delay));
    pdc_top DUT (.i_ref_clk, .i_arst_n, .i_cke, .i_cs, .i_cmd_addr_bus, .i_any_row_open,
        .i_self_refresh, .i_op_busy, .i_protected_busy, .i_cmd_needs_delay, .i_term_pad_en,
        .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .o_io_buf_en,
        .o_rx_en, .o_refresh_en, .o_pd_current_ok, .o_pd_mode, .o_cmd_term_en,
        .o_long_postamble, .o_cmd_accept, .o_cmd_word);

    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge i_ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            end_sim();
        end
    end
    // accepted commands, taken mid-cycle where outputs have settled
    always @(negedge i_ref_clk) begin
        if (o_cmd_accept === 1'h1) begin
            n_acc++;
            last_word = o_cmd_word;
        end
    end

    task automatic end_sim;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wait_n(input int n);
        ctl.step(n);
        #1;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_wr <= 1'h1;
        @(posedge i_ref_clk);
        i_reg_wr <= 1'h0;
    endtask
    task automatic rdc(input string nm, input logic [2:0] a, input logic [7:0] exp);
        @(posedge i_ref_clk);
        i_reg_addr <= a;
        i_reg_rd <= 1'h1;
        @(posedge i_ref_clk);
        i_reg_rd <= 1'h0;
        #1;
        chk(nm, exp, o_reg_rdata);
    endtask

    task automatic t_reset;
        chk("refresh", 8'h01, 8'(o_refresh_en));
        chk("postamble", 8'h00, 8'(o_long_postamble));
        rdc("status", REG_STATUS, {ST_AWAKE, PDM_NONE, 2'h3});
        rdc("cfg", REG_TERMINATION_CONFIG, TERM_CFG_RST);
        rdc("post", REG_BURST_POSTAMBLE, POSTAMBLE_RST);
        rdc("opt", REG_CMD_TERM_OPTION, TERM_OPT_RST);
        rdc("vio", REG_VIOLATION, 8'h00);
        rdc("unmapped", 3'h7, 8'h00);
    endtask
    // strap alone, both, option alone; the last setting stays for later entries
    task automatic t_term;
        logic [7:0] cfg [3] = '{8'h70, 8'h50, 8'h30};
        logic [2:0] opt [3] = '{3'h0, 3'h4, 3'h2};
        logic       pad [3] = '{1'h1, 1'h1, 1'h0};
        logic [2:0] term_exp [3] = '{3'h7, 3'h5, 3'h2};
        for (int i = 0; i < 3; i++) begin
            i_term_pad_en <= pad[i];
            wr(REG_TERMINATION_CONFIG, cfg[i]);
            wr(REG_CMD_TERM_OPTION, {5'h00, opt[i]});
            wait_n(2);
            chk("term", 8'(term_exp[i]), 8'(o_cmd_term_en));
        end
        wr(REG_BURST_POSTAMBLE, 8'h80);
        wait_n(2);
        chk("postamble", 8'h01, 8'(o_long_postamble));
        rdc("post", REG_BURST_POSTAMBLE, 8'h80);
    endtask
    // one refresh, entry, command while down, exit, command after latency
    task automatic t_pd(input logic row, input logic slf, input logic busy);
        logic [1:0] m;
        int         acc;
        m = slf ? PDM_SELF : (row ? PDM_ACTIVE : PDM_IDLE);
        i_any_row_open <= row;
        i_self_refresh <= slf;
        i_op_busy <= busy;
        ctl.issue(6'h11, 1'h1);
        ctl.pd_enter(2'h0);
        wait_n(4);
        chk("buf", 8'h00, 8'(o_io_buf_en));
        chk("rx early", 8'h01, 8'(o_rx_en));
        chk("mode", 8'(m), 8'(o_pd_mode));
        chk("refresh", 8'(slf), 8'(o_refresh_en));
        if (busy) chk("current", 8'h00, 8'(o_pd_current_ok));
        i_op_busy <= 1'h0;
        wait_n(8);
        chk("current", 8'h01, 8'(o_pd_current_ok));
        rdc("status", REG_STATUS, {ST_DOWN, m, 2'h0});
        chk("term", 8'h02, 8'(o_cmd_term_en));
        acc = n_acc;
        ctl.issue(6'h15, 1'h0);
        wait_n(2);
        chk("ignored", 8'(acc), 8'(n_acc));
        ctl.pd_exit(1'h0);
        #1;
        chk("refresh", 8'h01, 8'(o_refresh_en));
        rdc("status", REG_STATUS, {ST_AWAKE, PDM_NONE, 2'h3});
        ctl.issue(6'h2A ^ {4'h0, m}, 1'h0);
        wait_n(2);
        chk("accepted", 8'(acc + 1), 8'(n_acc));
        chk("word", {2'h0, 6'h2A ^ {4'h0, m}}, {2'h0, last_word});
        i_any_row_open <= 1'h0;
        i_self_refresh <= 1'h0;
    endtask
    // each controller fault raises its own flag; writing ones clears them
    task automatic t_viol;
        int bit_of [5] = '{VIO_BUSY_ENTRY, VIO_PULSE, VIO_EXIT_CMD, VIO_CS_HOLD, VIO_CMD_ENTRY};
        int acc;
        for (int i = 0; i < 5; i++) begin
            wr(REG_VIOLATION, 8'hFF);
            i_protected_busy <= (i == 0);
            ctl.issue(6'h09, 1'h1);
            ctl.pd_enter({i == 3, i == 4});
            if (i != 1) ctl.step(9);
            ctl.pd_exit(i == 2);
            acc = n_acc;
            if (i == 2) ctl.issue(6'h3C, 1'h0);
            wait_n(8);
            i_protected_busy <= 1'h0;
            chk("rushed", 8'(acc), 8'(n_acc));
            rdc("violation", REG_VIOLATION, 8'(1 << bit_of[i]));
        end
        wr(REG_VIOLATION, 8'hFF);
        rdc("cleared", REG_VIOLATION, 8'h00);
    endtask

    initial begin
        repeat (10) @(posedge i_ref_clk);
        i_arst_n <= 1'h1;
        wait_n(3);
        t_reset();
        t_term();
        t_pd(1'h0, 1'h0, 1'h0);
        t_pd(1'h1, 1'h0, 1'h1);
        t_pd(1'h0, 1'h1, 1'h0);
        t_viol();
        end_sim();
    end
endmodule // testbench
`default_nettype wire
